// ==== logic/addr_map_pkg.sv ====
package addr_map_pkg;
    localparam int REF_W = 17;
    localparam int PAGE_W = 8;
    localparam int OFFSET_W = 9;
    localparam int MAP_W = 13;
    localparam int LEGACY_W = 8;
    localparam int REAL_W = 22;
    localparam int EXT_W = 6;
    localparam int DISP_W = 16;
    localparam int PAGES = 256;
    localparam int ACC_W = 2;
    localparam int EXT_SEL_BIT = 16;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_MAP_INDEX = 4'h0;
    localparam logic [ADDR_W-1:0] REG_MAP_FULL = 4'h1;
    localparam logic [ADDR_W-1:0] REG_MAP_LEGACY = 4'h2;
    localparam logic [ADDR_W-1:0] REG_ACCESS = 4'h3;
    localparam logic [ADDR_W-1:0] REG_EXT_ADDR = 4'h4;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h5;
    localparam logic [ADDR_W-1:0] REG_MASK = 4'h6;
    localparam logic [ADDR_W-1:0] REG_MODE = 4'h7;
    localparam int EVT_W = 2;
    localparam int EVT_PROT = 0;
    localparam int EVT_PRIV = 1;
    localparam logic [1:0] ACC_NONE = 2'h3;
    localparam logic [1:0] ACC_READ = 2'h2;
    localparam logic [1:0] ACC_EXEC = 2'h1;
    typedef enum logic [2:0] {
        MODE_MASTER = 3'b001,
        MODE_SLAVE = 3'b010,
        MODE_PROTECTED = 3'b100
    } cpu_mode_e;
    typedef enum logic [2:0] {
        ADDR_REAL = 3'b001,
        ADDR_VIRTUAL = 3'b010,
        ADDR_EXTENDED = 3'b100
    } addr_kind_e;
endpackage

// ==== logic/mode_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
module mode_decoder
    import addr_map_pkg::*;
(
    input wire logic masterSlaveBit,
    input wire logic mapEnableBit,
    input wire logic modeAlteredFlag,
    output cpu_mode_e mode,
    output addr_kind_e kind
);
    always_comb begin
        if (masterSlaveBit) begin
            mode = MODE_SLAVE;
        end else if (mapEnableBit && modeAlteredFlag) begin
            mode = MODE_PROTECTED;
        end else begin
            mode = MODE_MASTER;
        end
        if (mapEnableBit) begin
            kind = ADDR_VIRTUAL;
        end else if (modeAlteredFlag) begin
            kind = ADDR_EXTENDED;
        end else begin
            kind = ADDR_REAL;
        end
    end
endmodule // mode_decoder
`default_nettype wire

// ==== logic/event_flags.sv ====
`timescale 1ns/1ps
`default_nettype none
module event_flags #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] setEvt,
    input wire logic clearAll,
    output logic [W-1:0] flags
);
    logic [W-1:0] flags_ff;
    logic [W-1:0] nxt_flags;
    always_comb begin
        nxt_flags = (clearAll ? '0 : flags_ff) | setEvt;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_ff <= '0;
        end else if (ce) begin
            flags_ff <= nxt_flags;
        end
    end
    assign flags = flags_ff;
endmodule // event_flags
`default_nettype wire

// ==== logic/cpu_mode_decode_and_address_map.sv ====
// Summary of operation
// - Master mode when master/slave bit and mode altered flag are both zero.
// - Master mode limits no accesses; access codes are not checked.
// - Master/slave bit one selects slave mode regardless of other bits.
// - Slave mode refuses privileged instructions; mapped slave references check access codes.
// - Master-protected when master/slave zero and map and mode altered both one.
// - Master-protected references prohibited by access code raise protection trap.
// - Unmapped, unextended addresses are 17-bit real word addresses.
// - Map enable bit one selects virtual addressing in master or slave mode.
// - Upper eight reference bits index one of 256 map registers.
// - Map entry replaces page bits, nine offset bits appended, 22-bit result.
// - Legacy map loads write eight low bits and clear upper five.
// - Extended map loads write all thirteen bits.
// - Pages are 512 words; virtual space is 256 pages.
// - Map bit zero with mode altered one selects real extended addressing.
// - Access protection is 256 two-bit entries loaded apart from the map.
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module cpu_mode_decode_and_address_map #(
    parameter int NUM_PAGES = addr_map_pkg::PAGES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic masterSlaveBit,
    input wire logic mapEnableBit,
    input wire logic modeAlteredFlag,
    input wire logic refValid,
    input wire logic [addr_map_pkg::REF_W-1:0] refAddr,
    input wire logic refWrite,
    input wire logic refFetch,
    input wire logic refPrivileged,
    input wire logic [addr_map_pkg::ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    output logic memValid,
    output logic [addr_map_pkg::REAL_W-1:0] memAddr,
    output logic protTrap,
    output logic privTrap,
    output logic [2:0] modeOut,
    output logic irq
);
    import addr_map_pkg::*;

    // ------------------------------------------------------------
    // Storage.
    // ------------------------------------------------------------
    logic [MAP_W-1:0] mapMem [NUM_PAGES];
    logic [ACC_W-1:0] accMem [NUM_PAGES];
    logic [PAGE_W-1:0] index_ff, nxt_index;
    logic [EXT_W-1:0] ext_ff, nxt_ext;
    logic [EVT_W-1:0] mask_ff, nxt_mask;
    logic [31:0] rdata_ff, nxt_rdata;
    logic memValid_ff, nxt_memValid;
    logic [REAL_W-1:0] memAddr_ff, nxt_memAddr;
    logic protTrap_ff, nxt_protTrap;
    logic privTrap_ff, nxt_privTrap;
    logic [2:0] mode_ff, nxt_mode;
    logic irq_ff, nxt_irq;
    cpu_mode_e mode;
    addr_kind_e kind;
    logic [EVT_W-1:0] flags;
    logic [EVT_W-1:0] evt;
    logic statusRead;
    logic [PAGE_W-1:0] page;
    logic [OFFSET_W-1:0] offset;
    logic [ACC_W-1:0] acc;
    logic checkAcc;
    logic denied;

    // ------------------------------------------------------------
    // Decode of current status bits, combinational per reference.
    // ------------------------------------------------------------
    mode_decoder u_dec (
        .masterSlaveBit(masterSlaveBit),
        .mapEnableBit(mapEnableBit),
        .modeAlteredFlag(modeAlteredFlag),
        .mode(mode),
        .kind(kind)
    );

    // ------------------------------------------------------------
    // Map and access storage writes.
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (ce && regWrite && regAddr == REG_MAP_FULL) begin
            mapMem[index_ff] <= regWdata[MAP_W-1:0];
        end
        if (ce && regWrite && regAddr == REG_MAP_LEGACY) begin
            mapMem[index_ff] <= {{(MAP_W-LEGACY_W){1'b0}}, regWdata[LEGACY_W-1:0]};
        end
        if (ce && regWrite && regAddr == REG_ACCESS) begin
            accMem[index_ff] <= regWdata[ACC_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Register interface.
    // ------------------------------------------------------------
    always_comb begin
        nxt_index = index_ff;
        nxt_ext = ext_ff;
        nxt_mask = mask_ff;
        nxt_rdata = '0;
        if (regWrite) begin
            case (regAddr)
                REG_MAP_INDEX: nxt_index = regWdata[PAGE_W-1:0];
                REG_EXT_ADDR: nxt_ext = regWdata[EXT_W-1:0];
                REG_MASK: nxt_mask = regWdata[EVT_W-1:0];
                default: nxt_index = index_ff;
            endcase
        end
        if (regRead) begin
            case (regAddr)
                REG_MAP_INDEX: nxt_rdata = {{(32-PAGE_W){1'b0}}, index_ff};
                REG_MAP_FULL: nxt_rdata = {{(32-MAP_W){1'b0}}, mapMem[index_ff]};
                REG_MAP_LEGACY: nxt_rdata = {{(32-MAP_W){1'b0}}, mapMem[index_ff]};
                REG_ACCESS: nxt_rdata = {{(32-ACC_W){1'b0}}, accMem[index_ff]};
                REG_EXT_ADDR: nxt_rdata = {{(32-EXT_W){1'b0}}, ext_ff};
                REG_STATUS: nxt_rdata = {{(32-EVT_W){1'b0}}, flags};
                REG_MASK: nxt_rdata = {{(32-EVT_W){1'b0}}, mask_ff};
                REG_MODE: nxt_rdata = {29'h0, mode};
                default: nxt_rdata = '0;
            endcase
        end
    end
    assign statusRead = regRead && regAddr == REG_STATUS;

    // ------------------------------------------------------------
    // Translation and protection.
    // ------------------------------------------------------------
    assign page = refAddr[REF_W-1:OFFSET_W];
    assign offset = refAddr[OFFSET_W-1:0];
    assign acc = accMem[page];
    // Master mode without protection ignores access codes.
    assign checkAcc = (kind == ADDR_VIRTUAL) &&
        (mode == MODE_SLAVE || mode == MODE_PROTECTED);
    always_comb begin
        case (acc)
            ACC_NONE: denied = 1'b1;
            ACC_READ: denied = refWrite;
            ACC_EXEC: denied = !refFetch;
            default: denied = 1'b0;
        endcase
    end
    always_comb begin
        nxt_memValid = 1'b0;
        nxt_memAddr = memAddr_ff;
        nxt_protTrap = 1'b0;
        nxt_privTrap = 1'b0;
        evt = '0;
        if (refValid) begin
            if (mode == MODE_SLAVE && refPrivileged) begin
                nxt_privTrap = 1'b1;
                evt[EVT_PRIV] = 1'b1;
            end else if (checkAcc && denied) begin
                nxt_protTrap = 1'b1;
                evt[EVT_PROT] = 1'b1;
            end else begin
                nxt_memValid = 1'b1;
                case (kind)
                    ADDR_VIRTUAL: nxt_memAddr = {mapMem[page], offset};
                    ADDR_EXTENDED: begin
                        if (refAddr[EXT_SEL_BIT]) begin
                            nxt_memAddr = {ext_ff, refAddr[DISP_W-1:0]};
                        end else begin
                            nxt_memAddr = {{(REAL_W-DISP_W){1'b0}}, refAddr[DISP_W-1:0]};
                        end
                    end
                    ADDR_REAL: nxt_memAddr = {{(REAL_W-REF_W){1'b0}}, refAddr};
                    default: nxt_memAddr = memAddr_ff;
                endcase
            end
        end
        nxt_mode = mode;
        nxt_irq = |(((statusRead ? '0 : flags) | evt) & nxt_mask);
    end

    event_flags #(
        .W(EVT_W)
    ) u_flags (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .setEvt(evt),
        .clearAll(statusRead),
        .flags(flags)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            index_ff <= '0;
            ext_ff <= '0;
            mask_ff <= '0;
            rdata_ff <= '0;
            memValid_ff <= 1'b0;
            memAddr_ff <= '0;
            protTrap_ff <= 1'b0;
            privTrap_ff <= 1'b0;
            mode_ff <= MODE_MASTER;
            irq_ff <= 1'b0;
        end else if (ce) begin
            index_ff <= nxt_index;
            ext_ff <= nxt_ext;
            mask_ff <= nxt_mask;
            rdata_ff <= nxt_rdata;
            memValid_ff <= nxt_memValid;
            memAddr_ff <= nxt_memAddr;
            protTrap_ff <= nxt_protTrap;
            privTrap_ff <= nxt_privTrap;
            mode_ff <= nxt_mode;
            irq_ff <= nxt_irq;
        end
    end

    assign regRdata = rdata_ff;
    assign memValid = memValid_ff;
    assign memAddr = memAddr_ff;
    assign protTrap = protTrap_ff;
    assign privTrap = privTrap_ff;
    assign modeOut = mode_ff;
    assign irq = irq_ff;
endmodule // cpu_mode_decode_and_address_map
`default_nettype wire

// ==== testbench/addr_map_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module addr_map_properties
    import addr_map_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic masterSlaveBit,
    input wire logic mapEnableBit,
    input wire logic modeAlteredFlag,
    input wire logic refValid,
    input wire logic [addr_map_pkg::REF_W-1:0] refAddr,
    input wire logic refPrivileged,
    input wire logic memValid,
    input wire logic [addr_map_pkg::REAL_W-1:0] memAddr,
    input wire logic protTrap,
    input wire logic privTrap,
    input wire logic [2:0] modeOut
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    logic take, master, prot, extLow;
    assign take = refValid && ce;
    assign master = !masterSlaveBit && !modeAlteredFlag;
    assign prot = !masterSlaveBit && mapEnableBit && modeAlteredFlag;
    assign extLow = !masterSlaveBit && !mapEnableBit && modeAlteredFlag && !refAddr[16];
    chk_master_mode: assert property (ce && master |=> modeOut == 3'h1)
        else $error("master mode not reported");
    chk_slave_mode: assert property (ce && masterSlaveBit |=> modeOut == 3'h2)
        else $error("slave mode not reported");
    chk_prot_mode: assert property (ce && prot |=> modeOut == 3'h4)
        else $error("protected mode not reported");
    chk_priv_refuse: assert property (take && masterSlaveBit && refPrivileged |=> privTrap)
        else $error("privileged slave reference accepted");
    chk_master_free: assert property (take && master |=> memValid && !protTrap)
        else $error("master reference refused");
    chk_real_addr: assert property (take && master && !mapEnableBit |=>
        memAddr == {5'h00, $past(refAddr)}) else $error("real address wrong");
    chk_page_offset: assert property (memValid && $past(ce) |->
        memAddr[8:0] == $past(refAddr[8:0]))
        else $error("word offset altered");
    chk_ext_low: assert property (take && extLow |=>
        memAddr == {6'h00, $past(refAddr[15:0])}) else $error("extended address wrong");
    chk_one_answer: assert property (take |=> $onehot({memValid, protTrap, privTrap}))
        else $error("reference answer not single");
    cov_prot: cover property (take && prot ##1 protTrap);
    cov_priv: cover property (privTrap);
    cov_virt: cover property (take && mapEnableBit ##1 memValid);
endmodule // addr_map_properties
`default_nettype wire

// ==== testbench/mem_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module mem_partner
    import addr_map_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic memValid,
    input wire logic [addr_map_pkg::REAL_W-1:0] memAddr,
    output logic [addr_map_pkg::REAL_W-1:0] lastAddr,
    output logic [7:0] count
);
    // Records each real word address that reaches memory.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lastAddr <= '0;
            count <= 8'h00;
        end else if (memValid) begin
            lastAddr <= memAddr;
            count <= count + 8'h01;
        end
    end
endmodule // mem_partner
`default_nettype wire

// ==== testbench/cpu_mode_decode_and_address_map_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpu_mode_decode_and_address_map_tb;
    import addr_map_pkg::*;
    logic clk, rst, ce, masterSlaveBit, mapEnableBit, modeAlteredFlag, refValid, refWrite;
    logic refPrivileged, regWrite, regRead, memValid, protTrap, privTrap, irq, refFetch;
    logic [REF_W-1:0] refAddr;
    logic [ADDR_W-1:0] regAddr;
    logic [31:0] regWdata, regRdata;
    logic [REAL_W-1:0] memAddr, lastAddr;
    logic [7:0] count;
    logic [2:0] modeOut;
    int fails, checks, hits;
    // Row: mode bits and write and privileged, address, answer, real address.
    logic [46:0] rows [11] = '{
        {5'h00, 17'h1F123, 3'h4, 22'h01F123}, {5'h01, 17'h00000, 3'h4, 22'h000000},
        {5'h08, 17'h00A05, 3'h4, 22'h357805}, {5'h0C, 17'h00A05, 3'h2, 22'h000000},
        {5'h18, 17'h00A05, 3'h2, 22'h000000}, {5'h11, 17'h00A05, 3'h1, 22'h000000},
        {5'h18, 17'h015FF, 3'h4, 22'h01FFFF}, {5'h1A, 17'h015FF, 3'h2, 22'h000000},
        {5'h04, 17'h12345, 3'h4, 22'h2A2345}, {5'h04, 17'h0BEEF, 3'h4, 22'h00BEEF},
        {5'h08, 17'h1FE00, 3'h4, 22'h200000}};
    cpu_mode_decode_and_address_map u_cpu_mode_decode_and_address_map (.clk, .rst, .ce,
        .masterSlaveBit, .mapEnableBit, .modeAlteredFlag, .refValid, .refAddr, .refWrite,
        .refFetch, .refPrivileged, .regAddr, .regWdata, .regWrite, .regRead,
        .regRdata, .memValid, .memAddr, .protTrap, .privTrap, .modeOut, .irq);
    mem_partner u_mem_partner (.clk, .rst, .memValid, .memAddr, .lastAddr, .count);
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'h1;
        @(posedge clk);
        regWrite <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'h1;
        @(posedge clk);
        regRead <= 1'h0;
        #1 chk(regRdata, e);
    endtask
    task automatic conclude();
        if (fails == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        conclude();
    end
    initial begin
        rst = 1'h1;
        ce = 1'h1;
        {masterSlaveBit, mapEnableBit, modeAlteredFlag, refValid, refWrite, refPrivileged} = '0;
        refFetch = 1'h0;
        {regWrite, regRead, regAddr, regWdata, refAddr} = '0;
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        #1 chk({irq, memValid, protTrap, privTrap, modeOut}, 32'h1);
        wr(REG_MAP_INDEX, 32'h5);
        wr(REG_MAP_FULL, 32'h1ABC);
        wr(REG_ACCESS, 32'h3);
        rd(REG_MAP_FULL, 32'h1ABC);
        wr(REG_MAP_INDEX, 32'hA);
        wr(REG_MAP_LEGACY, 32'h1FFF);
        wr(REG_ACCESS, 32'h2);
        rd(REG_MAP_LEGACY, 32'hFF);
        wr(REG_MAP_INDEX, 32'hFF);
        wr(REG_MAP_FULL, 32'h1000);
        wr(REG_EXT_ADDR, 32'h2A);
        rd(4'hF, 32'h0);
        for (int i = 0; i <= 11; i++) begin
            @(posedge clk);
            if (i < 11) begin
                {masterSlaveBit, mapEnableBit, modeAlteredFlag, refWrite, refPrivileged} <=
                    rows[i][46:42];
                refAddr <= rows[i][41:25];
                refValid <= 1'h1;
                hits += int'(rows[i][24]);
            end else begin
                refValid <= 1'h0;
            end
            if (i > 0) begin
                #1 chk({memValid, protTrap, privTrap}, rows[i-1][24:22]);
                if (rows[i-1][24]) chk(memAddr, rows[i-1][21:0]);
            end
        end
        @(posedge clk);
        #1 chk(lastAddr, 22'h200000);
        chk(count, hits);
        chk(irq, 1'h0);
        rd(REG_STATUS, 32'h3);
        rd(REG_STATUS, 32'h0);
        wr(REG_MASK, 32'h1);
        @(posedge clk);
        {masterSlaveBit, mapEnableBit, modeAlteredFlag} <= 3'h3;
        refAddr <= 17'h00A05;
        refValid <= 1'h1;
        @(posedge clk);
        refValid <= 1'h0;
        repeat (2) @(posedge clk);
        #1 chk(irq, 1'h1);
        rd(REG_STATUS, 32'h1);
        @(posedge clk);
        #1 chk(irq, 1'h0);
        wr(REG_ACCESS, 32'h1);
        @(posedge clk);
        refAddr <= 17'h1FE00;
        {refFetch, refValid} <= 2'h3;
        @(posedge clk);
        refFetch <= 1'h0;
        #1 chk({memValid, protTrap, privTrap, memAddr}, {3'h4, 22'h200000});
        @(posedge clk);
        refValid <= 1'h0;
        #1 chk({memValid, protTrap, privTrap}, 3'h2);
        @(posedge clk);
        rst <= 1'h1;
        @(posedge clk);
        rst <= 1'h0;
        #1 chk({irq, memValid, protTrap, privTrap, modeOut}, 32'h1);
        rd(REG_MAP_INDEX, 32'h0);
        rd(REG_MODE, 32'h4);
        @(posedge clk);
        ce <= 1'h0;
        refValid <= 1'h1;
        @(posedge clk);
        refValid <= 1'h0;
        ce <= 1'h1;
        #1 chk({memValid, protTrap, privTrap}, 3'h0);
        conclude();
    end
endmodule // cpu_mode_decode_and_address_map_tb
bind cpu_mode_decode_and_address_map addr_map_properties u_addr_map_properties (.clk, .rst,
    .ce, .masterSlaveBit, .mapEnableBit, .modeAlteredFlag, .refValid, .refAddr,
    .refPrivileged, .memValid, .memAddr, .protTrap, .privTrap, .modeOut);
`default_nettype wire
